// ==== sld_pkg.sv ====
// shared constants, types and register map of the sponge datapath
// assumes a single 100 mhz clock domain and an apb slave with 32-bit data
package sld_pkg;

    // --------------------------------------------------------------
    // state geometry
    // --------------------------------------------------------------
    localparam int STAGES = 37;     // shift register stages
    localparam int SW = 7;          // bits per stage
    localparam int RATE = 10;       // rate slices
    localparam int BLK = 64;        // input block width
    localparam int PAD = RATE * SW; // block padded with zeros
    localparam int NTAPS = 10;      // linear feedback taps
    localparam int NSB = 4;         // small sbox instances
    localparam int SBOX_ROUNDS = 5; // cascaded r steps per sbox
    localparam int ROUND_W = 16;    // round counter width
    localparam int FIFO_DEPTH = 8;  // input block buffer depth

    typedef logic [SW-1:0] sld_slice_t;

    // stage fed by each rate slice
    localparam int RATE_STAGE [RATE] = '{8, 9, 15, 16, 18, 27, 28, 34, 35, 36};
    // tap stages, the first one passes the omega multiplier
    localparam int TAPS [NTAPS] = '{0, 6, 8, 12, 13, 19, 24, 26, 30, 31};
    // small sbox sources and destinations
    localparam int SBOX_SRC [NSB] = '{8, 15, 27, 34};
    localparam int SBOX_DST [NSB] = '{4, 10, 23, 29};
    localparam int FPERM_SRC = 18;  // inner field permutation tap
    localparam int FPERM_DST = 18;
    localparam int LAST = 36;       // feedback stage

    localparam logic [RATE-1:0] LOAD_SLICES = 10'h239; // slices 9,5,4,3,0
    localparam logic [RATE-1:0] MASK_SLICES = 10'h04A; // slices 6,3,1
    localparam logic [SW-1:0] FIELD_POLY = 7'h03;      // reduction term
    localparam logic [SW-1:0] RC_RESET = 7'h7F;        // round constant seed

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DIN_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DIN_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ROUNDS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DOUT_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DOUT_HI = 8'h18;
    localparam int ST_BUSY = 0;
    localparam int ST_EMPTY = 1;
    localparam int ST_FULL = 2;
    localparam int ST_OUTV = 3;

    // datapath controls, one per step
    typedef struct packed {
        logic load;
        logic absorb;
        logic replace;
        logic tagPhase;
        logic sboxBypass;
        logic genOut;
        logic [1:0] domSep;
    } sld_ctrl_s;

    localparam int CTRL_W = $bits(sld_ctrl_s);

endpackage

// ==== sld_datapath.sv ====
// sponge datapath: 37x7 shift state, nonlinear taps, apb registers, block fifo
// assumes one clock, synchronous active-low reset, an apb master on the bus
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// block buffer
// ------------------------------------------------------------------
module sld_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // filling side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // draining side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad
            $error("fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic [PW:0] wrPtr_q;           // extra bit tells full from empty
    logic [PW:0] rdPtr_q;
    logic push;
    logic pop;

    assign inReady = (wrPtr_q - rdPtr_q) != (PW + 1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData = mem[rdPtr_q[PW-1:0]];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // storage write, no reset needed for data
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_q[PW-1:0]] <= inData;
        end
    end

    // pointers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule

// ------------------------------------------------------------------
// top: state, step logic and register slave
// ------------------------------------------------------------------
module sld_datapath #(
    parameter int FIFO_DEPTH = sld_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sld_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // produced blocks
    output logic [sld_pkg::BLK-1:0] outBlock,
    output logic outValid
);
    // --------------------------------------------------------------
    // field helpers
    // --------------------------------------------------------------
    function automatic sld_pkg::sld_slice_t mulOmega(input sld_pkg::sld_slice_t x);
        return {x[5:0], 1'b0} ^ (x[6] ? sld_pkg::FIELD_POLY : '0);
    endfunction

    function automatic sld_pkg::sld_slice_t fieldMul(input sld_pkg::sld_slice_t a,
                                                     input sld_pkg::sld_slice_t b);
        sld_pkg::sld_slice_t p;
        sld_pkg::sld_slice_t aa;
        p = '0;
        aa = a;
        for (int i = 0; i < sld_pkg::SW; i++) begin
            if (b[i]) begin
                p = p ^ aa;
            end
            aa = mulOmega(aa);
        end
        return p;
    endfunction

    // power map x^13, a bijection on the 7-bit field
    function automatic sld_pkg::sld_slice_t nonlinear_field_permutation(
        input sld_pkg::sld_slice_t x);
        sld_pkg::sld_slice_t x2;
        sld_pkg::sld_slice_t x4;
        sld_pkg::sld_slice_t x8;
        x2 = fieldMul(x, x);
        x4 = fieldMul(x2, x2);
        x8 = fieldMul(x4, x4);
        return fieldMul(fieldMul(x8, x4), x);
    endfunction

    // one nonlinear step of the small sbox
    function automatic sld_pkg::sld_slice_t rStep(input sld_pkg::sld_slice_t x);
        sld_pkg::sld_slice_t r;
        r = x;
        r[0] = x[0] ^ (x[2] & x[3]);
        r[4] = x[4] ^ (x[1] & x[5]);
        return {r[5:0], r[6]};
    endfunction

    // unrolled sbox, purely combinational
    function automatic sld_pkg::sld_slice_t small_sbox(input sld_pkg::sld_slice_t x);
        sld_pkg::sld_slice_t y;
        y = x;
        for (int i = 0; i < sld_pkg::SBOX_ROUNDS; i++) begin
            y = rStep(y);
        end
        y = {y[0], y[6:1]};   // q stage
        y[0] = ~y[0];
        y[5] = ~y[5];
        return y;
    endfunction

    // --------------------------------------------------------------
    // state and control
    // --------------------------------------------------------------
    sld_pkg::sld_slice_t st_q [sld_pkg::STAGES];  // full cipher state
    sld_pkg::sld_slice_t st_d [sld_pkg::STAGES];
    sld_pkg::sld_slice_t shiftV [sld_pkg::STAGES]; // value shifted in
    sld_pkg::sld_slice_t din [sld_pkg::RATE];      // gated input slices
    sld_pkg::sld_slice_t outSl [sld_pkg::RATE];    // output slices
    logic [sld_pkg::SW-1:0] rc_q;                  // round constant state
    logic [sld_pkg::ROUND_W-1:0] rounds_q;         // rounds still to run
    sld_pkg::sld_ctrl_s ctrl_q;                    // software controls
    sld_pkg::sld_ctrl_s stepCtl;                   // controls of this step
    logic [31:0] dinLo_q;                          // low half of next block
    logic [sld_pkg::PAD-1:0] padded;
    logic [sld_pkg::BLK-1:0] outCat;
    logic permuting;
    logic popFifo;
    logic doStep;
    logic hold;                                    // shift enable low
    logic outAvail_q;                              // unread output held
    logic [sld_pkg::BLK-1:0] fifoData;
    logic fifoValid;
    logic fifoInReady;
    logic accessing;
    logic pushBlk;
    logic ack;
    logic wrEn;
    logic rdHi;
    logic mapped;

    // buffer drains only while no rounds run, so it really fills
    assign permuting = rounds_q != '0;
    assign popFifo = !permuting && fifoValid;
    assign doStep = permuting || popFifo;
    assign stepCtl = popFifo ? ctrl_q : '0;
    assign hold = stepCtl.absorb || stepCtl.replace;
    assign padded = {{(sld_pkg::PAD - sld_pkg::BLK){1'b0}}, fifoData};

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    // shift path, feedback, nonlinear taps, then sponge muxes
    always_comb begin
        sld_pkg::sld_slice_t fb;
        logic rl;
        int j;
        rl = 1'b0;
        j = 0;
        fb = mulOmega(st_q[sld_pkg::TAPS[0]]);
        for (int t = 1; t < sld_pkg::NTAPS; t++) begin
            fb = fb ^ st_q[sld_pkg::TAPS[t]];
        end
        for (int s = 0; s < sld_pkg::LAST; s++) begin
            shiftV[s] = st_q[s+1];
        end
        shiftV[sld_pkg::LAST] = fb ^ nonlinear_field_permutation(st_q[sld_pkg::LAST])
                                ^ {rc_q[0], rc_q[6:1]};
        shiftV[sld_pkg::FPERM_DST] = shiftV[sld_pkg::FPERM_DST] ^ rc_q
                                     ^ nonlinear_field_permutation(st_q[sld_pkg::FPERM_SRC]);
        for (int i = 0; i < sld_pkg::NSB; i++) begin
            // sboxes cut off while bypassed
            if (!stepCtl.sboxBypass) begin
                shiftV[sld_pkg::SBOX_DST[i]] = shiftV[sld_pkg::SBOX_DST[i]]
                                              ^ small_sbox(st_q[sld_pkg::SBOX_SRC[i]]);
            end
        end
        // non-input stages hold while absorbing or replacing, except stage 0, which adds domSep
        for (int s = 0; s < sld_pkg::STAGES; s++) begin
            st_d[s] = hold ? st_q[s] : shiftV[s];
        end
        if (hold) begin
            st_d[0] = st_q[0] ^ {5'h00, stepCtl.domSep};
        end
        for (int k = 0; k < sld_pkg::RATE; k++) begin
            j = sld_pkg::RATE_STAGE[k];
            din[k] = padded[k*sld_pkg::SW +: sld_pkg::SW];
            if (stepCtl.tagPhase && sld_pkg::MASK_SLICES[k]) begin
                din[k] = '0;
            end
            outSl[k] = st_q[j] ^ din[k];
            if (stepCtl.absorb) begin
                st_d[j] = outSl[k];
            end
            rl = stepCtl.replace || (stepCtl.load && sld_pkg::LOAD_SLICES[k]);
            if (rl) begin
                st_d[j] = din[k];
            end
        end
        outCat = '0;
        for (int k = 0; k < sld_pkg::RATE; k++) begin
            outCat = outCat | sld_pkg::BLK'(sld_pkg::PAD'(outSl[k]) << (k * sld_pkg::SW));
        end
    end

    // state update, one step per accepted block or round
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int s = 0; s < sld_pkg::STAGES; s++) begin
                st_q[s] <= '0;
            end
        end else if (doStep) begin
            st_q <= st_d;
        end
    end

    // round constants advance two bits per round
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rc_q <= sld_pkg::RC_RESET;
        end else if (popFifo && stepCtl.load) begin
            rc_q <= sld_pkg::RC_RESET;
        end else if (permuting) begin
            rc_q <= {rc_q[4:0], rc_q[6] ^ rc_q[5], rc_q[5] ^ rc_q[4]};
        end
    end

    // output block only when the step asks for it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            outBlock <= '0;
            outValid <= 1'b0;
        end else begin
            outValid <= popFifo && stepCtl.genOut;
            if (popFifo && stepCtl.genOut) begin
                outBlock <= outCat;
            end
        end
    end

    // --------------------------------------------------------------
    // buffer
    // --------------------------------------------------------------
    sld_fifo #(
        .WIDTH(sld_pkg::BLK),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inData({pwdata, dinLo_q}),
        .inValid(pushBlk),
        .inReady(fifoInReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(popFifo)
    );

    // --------------------------------------------------------------
    // apb slave
    // --------------------------------------------------------------
    // a full buffer stalls the high-word write by holding pready low
    assign accessing = psel && penable && !pready;
    assign mapped = paddr inside {sld_pkg::OFS_CTRL, sld_pkg::OFS_DIN_LO,
                                  sld_pkg::OFS_DIN_HI, sld_pkg::OFS_ROUNDS,
                                  sld_pkg::OFS_STATUS, sld_pkg::OFS_DOUT_LO,
                                  sld_pkg::OFS_DOUT_HI};
    assign pushBlk = accessing && pwrite && paddr == sld_pkg::OFS_DIN_HI && fifoInReady;
    assign ack = accessing && (!(pwrite && paddr == sld_pkg::OFS_DIN_HI) || fifoInReady);
    assign wrEn = ack && pwrite;
    assign rdHi = ack && !pwrite && paddr == sld_pkg::OFS_DOUT_HI;

    // handshake and read data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= ack;
            pslverr <= ack && !mapped;
            prdata <= '0;
            if (ack && !pwrite) begin
                case (paddr)
                    sld_pkg::OFS_CTRL: prdata <= 32'(ctrl_q);
                    sld_pkg::OFS_DIN_LO: prdata <= dinLo_q;
                    sld_pkg::OFS_ROUNDS: prdata <= 32'(rounds_q);
                    sld_pkg::OFS_STATUS: begin
                        prdata[sld_pkg::ST_BUSY] <= permuting;
                        prdata[sld_pkg::ST_EMPTY] <= !fifoValid;
                        prdata[sld_pkg::ST_FULL] <= !fifoInReady;
                        prdata[sld_pkg::ST_OUTV] <= outAvail_q;
                    end
                    sld_pkg::OFS_DOUT_LO: prdata <= outBlock[31:0];
                    sld_pkg::OFS_DOUT_HI: prdata <= outBlock[63:32];
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // control and low data word
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            dinLo_q <= '0;
        end else if (wrEn) begin
            if (paddr == sld_pkg::OFS_CTRL) begin
                ctrl_q <= pwdata[sld_pkg::CTRL_W-1:0];
            end
            if (paddr == sld_pkg::OFS_DIN_LO) begin
                dinLo_q <= pwdata;
            end
        end
    end

    // round counter: software loads, each round counts down
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rounds_q <= '0;
        end else if (wrEn && paddr == sld_pkg::OFS_ROUNDS) begin
            rounds_q <= pwdata[sld_pkg::ROUND_W-1:0];
        end else if (permuting) begin
            rounds_q <= rounds_q - 1'b1;
        end
    end

    // unread output flag, a new block wins over the clearing read
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            outAvail_q <= 1'b0;
        end else if (popFifo && stepCtl.genOut) begin
            outAvail_q <= 1'b1;
        end else if (rdHi) begin
            outAvail_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_perm_shift: assert property (
        permuting |=> st_q[0] == $past(st_q[1]) && st_q[35] == $past(st_q[36]))
        else $error("permutation did not shift the state");
    a_hold_other: assert property (
        popFifo && hold |=> st_q[1] == $past(st_q[1]) && st_q[20] == $past(st_q[20]))
        else $error("non-input stage moved while holding");
    a_absorb_xor: assert property (
        popFifo && stepCtl.absorb && !stepCtl.replace && !stepCtl.load
        |=> st_q[8] == $past(st_q[8] ^ padded[6:0]))
        else $error("absorb did not xor slice zero");
    a_replace_data: assert property (
        popFifo && stepCtl.replace && !stepCtl.tagPhase |=> st_q[9] == $past(padded[13:7]))
        else $error("replace did not overwrite slice one");
    a_load_slice: assert property (
        popFifo && stepCtl.load && !hold
        |=> st_q[8] == $past(padded[6:0]) && st_q[9] == $past(st_q[10]))
        else $error("load path wrong");
    a_domsep_add: assert property (
        popFifo && hold |=> st_q[0] == ($past(st_q[0]) ^ {5'h00, $past(stepCtl.domSep)}))
        else $error("domain separator not added");
    a_tag_mask: assert property (
        popFifo && stepCtl.tagPhase |-> din[1] == '0 && din[3] == '0 && din[6] == '0)
        else $error("tag phase passed masked input");
    a_sbox_off: assert property (
        popFifo && stepCtl.sboxBypass && !hold |=> st_q[4] == $past(st_q[5]))
        else $error("sbox reached state while bypassed");
    a_out_only: assert property (
        outValid |-> $past(popFifo && stepCtl.genOut) && outBlock == $past(outCat))
        else $error("output produced outside an output step");
    a_round_run: assert property (
        permuting |-> !popFifo && !outValid ##1 (rounds_q == $past(rounds_q) - 1'b1))
        else $error("round step took a block");

    c_load_step: cover property (popFifo && stepCtl.load);
    c_encrypt_out: cover property (popFifo && stepCtl.absorb && stepCtl.genOut ##1 outValid);
    c_perm_done: cover property (permuting ##1 !permuting ##[1:4] popFifo);
    c_fifo_full: cover property (!fifoInReady && psel && penable);
endmodule

// ==== sld_host_model.sv ====
// apb master standing in for the host that programs the sponge datapath
// assumes one clock; the bench calls xfer and notes expectations itself
`timescale 1ns/1ps

// ------------------------------------------------------------------
// host bus master
// ------------------------------------------------------------------
module sld_host_model (
    // clock
    input wire logic ref_clk,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [sld_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    // apb answer
    input wire logic pready
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // one transfer: setup, then access until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // no cycle count assumed, a full buffer may stall for a whole permutation
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // released address and data lines show the inverse, never a stale copy
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ==== sld_datapath_test.sv ====
// self-checking bench for the sponge datapath, expectations kept in queues
// assumes the host model drives apb and the design answers per its contract
`timescale 1ns/1ps

module sld_datapath_test;
    // ------------------------------------------------------------------
    // clock, reset, wiring
    // ------------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, outValid;
    logic [sld_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [sld_pkg::BLK-1:0] outBlock;
    int nErrors = 0;
    int checksDone = 0;
    logic [32:0] rdQ[$]; // expected {pslverr, prdata} per transfer
    logic [63:0] outQ[$]; // expected produced blocks
    logic [31:0] seed = 32'hb773_9799;
    // input slices 6,3,1 blanked in tag phase
    localparam logic [63:0] MSK = 64'h0001_FC00_0FE0_3F80;

    always #5 ref_clk = ~ref_clk;

    sld_host_model host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));

    sld_datapath #(.FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .outBlock(outBlock), .outValid(outValid));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // xorshift source, fixed seed keeps runs repeatable
    function logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task check(input string nm, input logic [63:0] exp, input logic [63:0] seen);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task tally_and_finish();
        if (nErrors == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // reset held 12 cycles, released on the sampling edge
    task reset_dut();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    task xact(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        rdQ.push_back(e);
        host.xfer(wr, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        xact(1'b0, a, 32'h0000_0000, {1'b0, e});
    endtask

    // one step: controls first, then the block pair that pushes it
    task blk(input logic [7:0] c, input logic [63:0] d, input logic gen, input logic [63:0] e);
        xact(1'b1, sld_pkg::OFS_CTRL, {24'h00_0000, c}, 33'h0_0000_0000);
        if (gen)
            outQ.push_back(e);
        xact(1'b1, sld_pkg::OFS_DIN_LO, d[31:0], 33'h0_0000_0000);
        xact(1'b1, sld_pkg::OFS_DIN_HI, d[63:32], 33'h0_0000_0000);
    endtask

    // ------------------------------------------------------------------
    // monitors: oldest note against each answer
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        // every apb answer carries data and error flag
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (rdQ.size() == 0)
                check("apb unexpected", 64'h0, 64'h1);
            else
                check("apb answer", {31'h0, rdQ.pop_front()}, {31'h0, pslverr, prdata});
        end
        // a produced block must have been announced
        if (rst_n === 1'b1 && outValid !== 1'b0) begin
            if (outQ.size() == 0)
                check("unexpected block", 64'h0, 64'h1);
            else
                check("out block", outQ.pop_front(), outBlock);
        end
    end

    // watchdog, run needs well under 3000 cycles
    initial begin
        #100us;
        nErrors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [63:0] st, v;
        reset_dut();
        rd(sld_pkg::OFS_STATUS, 32'h0000_0002);
        // unmapped places refuse with an error
        xact(1'b0, 8'h1C, 32'h0000_0000, 33'h1_0000_0000);
        xact(1'b1, 8'h20, nxt(), 33'h1_0000_0000);
        // load steps behind a long permutation fill the buffer
        xact(1'b1, sld_pkg::OFS_CTRL, 32'h0000_0088, 33'h0_0000_0000);
        xact(1'b1, sld_pkg::OFS_ROUNDS, 32'h0000_012C, 33'h0_0000_0000);
        for (int i = 0; i < 8; i++)
            blk(8'h88, {nxt(), nxt()}, 1'b0, 64'h0);
        rd(sld_pkg::OFS_STATUS, 32'h0000_0005);
        // ninth block stalls until the rounds end and the buffer frees a slot
        blk(8'h88, {nxt(), nxt()}, 1'b0, 64'h0);
        repeat (20) @(posedge ref_clk);
        rd(sld_pkg::OFS_STATUS, 32'h0000_0002);
        rd(sld_pkg::OFS_CTRL, 32'h0000_0088);
        rd(sld_pkg::OFS_ROUNDS, 32'h0000_0000);
        // second reset in mid-run, state back to zero
        reset_dut();
        // masked absorb from a zero state
        v = {nxt(), nxt()};
        st = v & ~MSK;
        blk(8'h54, v, 1'b1, st);
        // encrypt, decrypt by replacement, then encrypt again
        v = {nxt(), nxt()};
        blk(8'h46, v, 1'b1, st ^ v);
        st = st ^ v;
        v = {nxt(), nxt()};
        blk(8'h26, v, 1'b1, st ^ v);
        st = v;
        v = {nxt(), nxt()};
        blk(8'h46, v, 1'b1, st ^ v);
        st = st ^ v;
        // absorb of associated data produces nothing
        v = {nxt(), nxt()};
        blk(8'h41, v, 1'b0, 64'h0);
        st = st ^ v;
        v = {nxt(), nxt()};
        blk(8'h46, v, 1'b1, st ^ v);
        st = st ^ v;
        // result readback clears the unread flag
        rd(sld_pkg::OFS_STATUS, 32'h0000_000A);
        rd(sld_pkg::OFS_DOUT_LO, st[31:0]);
        rd(sld_pkg::OFS_DOUT_HI, st[63:32]);
        rd(sld_pkg::OFS_DIN_LO, v[31:0]);
        rd(sld_pkg::OFS_STATUS, 32'h0000_0002);
        repeat (5) @(posedge ref_clk);
        check("blocks left", 64'h0, 64'(outQ.size()));
        check("answers left", 64'h0, 64'(rdQ.size()));
        tally_and_finish();
    end
endmodule
